// [rtl/wtr_top.sv]
// register bank giving software access to the transmit template ram
// Summary of operation
// R1: direction 0 writes sample to ram, 1 reads it back; arbitrary mode only; read data lands in readback_q, which no bus read returns.
// R2: five-bit sample index addresses ram, zero at reset, up to 10010.
// R3: seven-bit template word is stored at the indexed ram location.
// R4: template word holds its value until software writes a new one.
// R5: sample data register is read/write, resets to zero, top bit reserved.
// R6: index and word ignored for ram access unless selector top bit set.
// R7: selector 0000-0111 picks presets; top bit set picks arbitrary waveform.
// R8: completion flag in control bit 6 sets when ram access has finished.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "wtr_consts.svh"
module wtr_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic arb_waveform_sel,
  output logic [2:0] preset_template
);
  logic [11:0] awaddr_q;
  logic aw_held_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_held_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [3:0] pulse_template_select_q;
  logic dir_q;
  wtr_pkg::wtr_index_t sample_index_q;
  logic done_q;
  wtr_pkg::wtr_word_t template_word_q;
  wtr_pkg::wtr_state_t state_q;
  logic do_write;
  logic ctrl_wr;
  logic data_wr;
  logic sel_wr;
  logic arb_mode;
  wtr_ram_if ram_bus ();

  function automatic logic known_addr(input logic [11:0] a);
    known_addr = (a == `WTR_ADDR_ACCESS_CTRL) ||
      (a == `WTR_ADDR_SAMPLE_DATA) || (a == `WTR_ADDR_PULSE_SEL);
  endfunction : known_addr

  // write channel: address and data accepted in either order
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  assign ctrl_wr = do_write && awaddr_q == `WTR_ADDR_ACCESS_CTRL &&
    wstrb_q[0];
  assign data_wr = do_write && awaddr_q == `WTR_ADDR_SAMPLE_DATA &&
    wstrb_q[0];
  assign sel_wr = do_write && awaddr_q == `WTR_ADDR_PULSE_SEL && wstrb_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= {s_axi_awaddr[11:2], 2'h0};
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `WTR_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= known_addr(awaddr_q) ? `WTR_RESP_OKAY : `WTR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // pulse template selector: top bit picks the arbitrary waveform
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_template_select_q <= `WTR_RST_PULSE_SEL;
    end else if (sel_wr) begin
      pulse_template_select_q <= wdata_q[3:0];
    end
  end

  assign arb_mode = pulse_template_select_q[`WTR_BIT_ARB]; // R7
  assign arb_waveform_sel = arb_mode; // R7
  assign preset_template = pulse_template_select_q[2:0]; // R7

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_q <= 1'b0; // R1
      sample_index_q <= 5'h00; // R2
    end else if (ctrl_wr) begin
      dir_q <= wdata_q[`WTR_BIT_DIR];
      sample_index_q <= wdata_q[4:0]; // R2
    end
  end

  // word changes only on software write; a ram read never overwrites it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      template_word_q <= 7'h00; // R5
    end else if (data_wr) begin
      template_word_q <= wdata_q[6:0]; // R4
    end
  end

  // a control write starts one access, only in arbitrary mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= wtr_pkg::WTR_IDLE;
    end else begin
      case (state_q)
        wtr_pkg::WTR_IDLE: begin
          if (ctrl_wr && arb_mode) begin // R6
            state_q <= wtr_pkg::WTR_ACCESS;
          end
        end
        wtr_pkg::WTR_ACCESS: state_q <= wtr_pkg::WTR_FINISH;
        wtr_pkg::WTR_FINISH: state_q <= wtr_pkg::WTR_IDLE;
        default: state_q <= wtr_pkg::WTR_IDLE;
      endcase
    end
  end

  assign ram_bus.wr_en = state_q == wtr_pkg::WTR_ACCESS && !dir_q &&
    arb_mode; // R1
  assign ram_bus.rd_en = state_q == wtr_pkg::WTR_ACCESS && dir_q &&
    arb_mode; // R1
  assign ram_bus.addr = sample_index_q; // R2
  assign ram_bus.wdata = template_word_q; // R3

  wtr_ram u_ram (
    .aclk(aclk),
    .port(ram_bus)
  );

  // set wins: a new control write clears, finish sets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
    end else if (state_q == wtr_pkg::WTR_FINISH) begin
      done_q <= 1'b1; // R8
    end else if (ctrl_wr) begin
      done_q <= 1'b0;
    end
  end

  // read-back data for a ram read is captured in readback_q, which no bus register read returns
  wtr_pkg::wtr_word_t readback_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      readback_q <= 7'h00;
    end else if (state_q == wtr_pkg::WTR_FINISH && dir_q) begin
      readback_q <= ram_bus.rdata; // R1
    end
  end

  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `WTR_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q <= `WTR_RESP_OKAY;
      case ({s_axi_araddr[11:2], 2'h0})
        `WTR_ADDR_ACCESS_CTRL:
          rdata_q <= {25'h0000000, done_q, dir_q, sample_index_q}; // R8
        `WTR_ADDR_SAMPLE_DATA: rdata_q <= {25'h0000000, template_word_q}; // R5
        `WTR_ADDR_PULSE_SEL: rdata_q <= {28'h0000000, pulse_template_select_q};
        default: begin
          rdata_q <= 32'h00000000;
          rresp_q <= `WTR_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ---- assertions
  a_done_after_access: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == wtr_pkg::WTR_ACCESS |-> ##2 done_q) // R8
    else $error("done flag not set two cycles after access");
  a_no_access_preset: assert property (@(posedge aclk) disable iff (!aresetn)
    !arb_mode |-> !ram_bus.wr_en && !ram_bus.rd_en) // R6
    else $error("ram accessed outside arbitrary mode");
  a_write_dir: assert property (@(posedge aclk) disable iff (!aresetn)
    ram_bus.wr_en |-> !dir_q && !ram_bus.rd_en) // R1
    else $error("ram write while direction is read");
  a_start_access: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == wtr_pkg::WTR_IDLE && ctrl_wr && arb_mode |=>
      state_q == wtr_pkg::WTR_ACCESS) // R6
    else $error("control write in arbitrary mode did not start access");
  a_word_stable: assert property (@(posedge aclk) disable iff (!aresetn)
    !data_wr |=> $stable(template_word_q)) // R4
    else $error("template word changed without a write");
  a_index_load: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_wr |=> sample_index_q == $past(wdata_q[4:0])) // R2
    else $error("sample index not loaded from control write");
  a_word_load: assert property (@(posedge aclk) disable iff (!aresetn)
    data_wr |=> template_word_q == $past(wdata_q[6:0])) // R3
    else $error("template word not loaded");
  a_data_top_bit: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid_q |-> rdata_q[31:7] == 25'h0000000) // R5
    else $error("reserved data bit read as one");
  a_arb_select: assert property (@(posedge aclk) disable iff (!aresetn)
    sel_wr |=>
      arb_waveform_sel == $past(wdata_q[`WTR_BIT_ARB])) // R7
    else $error("arbitrary select does not follow selector top bit");
  // ram sequencing and register loads
  a_preset_no_start: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == wtr_pkg::WTR_IDLE && ctrl_wr && !arb_mode |=>
      state_q == wtr_pkg::WTR_IDLE) // R6
    else $error("control write in preset mode started an access");
  a_finish_next: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == wtr_pkg::WTR_ACCESS |=> state_q == wtr_pkg::WTR_FINISH) // R8
    else $error("access did not move to finish");
  a_finish_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == wtr_pkg::WTR_FINISH |=> state_q == wtr_pkg::WTR_IDLE) // R8
    else $error("finish did not return to idle");
  a_done_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_wr && state_q != wtr_pkg::WTR_FINISH |=> !done_q) // R8
    else $error("control write did not clear done flag");
  a_dir_load: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_wr |=> dir_q == $past(wdata_q[`WTR_BIT_DIR])) // R1
    else $error("direction bit not loaded from control write");
  a_read_dir: assert property (@(posedge aclk) disable iff (!aresetn)
    ram_bus.rd_en |-> dir_q && !ram_bus.wr_en) // R1
    else $error("ram read while direction is write");
  a_readback_load: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == wtr_pkg::WTR_FINISH && dir_q |=>
      readback_q == $past(ram_bus.rdata)) // R1
    else $error("ram read-back value not captured");
  a_access_write: assert property (@(posedge aclk) disable iff (!aresetn)
    ram_bus.wr_en |-> ram_bus.wdata == template_word_q &&
      ram_bus.addr == sample_index_q) // R3
    else $error("ram write does not carry word and index");
  a_sel_load: assert property (@(posedge aclk) disable iff (!aresetn)
    sel_wr |=> pulse_template_select_q == $past(wdata_q[3:0])) // R7
    else $error("selector not loaded from write");
  // bus handshake
  a_bvalid_after: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid)
    else $error("write response not raised after write");
  a_bresp_slverr: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && !known_addr(awaddr_q) |=> s_axi_bresp == `WTR_RESP_SLVERR)
    else $error("unmapped write not answered with slave error");
  a_ready_block: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready while response pending");
  a_arready_block: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address ready while read data pending");
  a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_rresp_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rresp == `WTR_RESP_SLVERR |->
      s_axi_rdata == 32'h00000000) // R5
    else $error("unmapped read returned nonzero data");
endmodule : wtr_top
`default_nettype wire

// [rtl/wtr_consts.svh]
// offsets, field positions, reset values and sizes for the template ram block
`ifndef WTR_CONSTS_SVH
`define WTR_CONSTS_SVH
// offsets printed as indices; byte address is four times the index
`define WTR_IDX_ACCESS_CTRL 8'h08
`define WTR_IDX_SAMPLE_DATA 8'h09
`define WTR_IDX_PULSE_SEL 8'h06
`define WTR_ADDR_ACCESS_CTRL 12'h020
`define WTR_ADDR_SAMPLE_DATA 12'h024
`define WTR_ADDR_PULSE_SEL 12'h018
`define WTR_RST_ACCESS_CTRL 8'h00
`define WTR_RST_SAMPLE_DATA 8'h00
`define WTR_RST_PULSE_SEL 4'h2
`define WTR_BIT_DONE 6
`define WTR_BIT_DIR 5
`define WTR_BIT_ARB 3
`define WTR_SAMPLES 19
`define WTR_LAST_INDEX 5'h12
`define WTR_RESP_OKAY 2'h0
`define WTR_RESP_SLVERR 2'h2
`endif

// [rtl/wtr_pkg.sv]
// types for the template ram block
`default_nettype none
package wtr_pkg;
  typedef enum logic [1:0] {
    WTR_IDLE,
    WTR_ACCESS,
    WTR_FINISH
  } wtr_state_t;
  typedef logic [4:0] wtr_index_t;
  typedef logic [6:0] wtr_word_t;
endpackage : wtr_pkg
`default_nettype wire

// [rtl/wtr_ram_if.sv]
// request and answer signals between control logic and template ram
`timescale 1ns/1ps
`default_nettype none
interface wtr_ram_if;
  logic wr_en;
  logic rd_en;
  wtr_pkg::wtr_index_t addr;
  wtr_pkg::wtr_word_t wdata;
  wtr_pkg::wtr_word_t rdata;
  modport ctrl (output wr_en, output rd_en, output addr, output wdata,
    input rdata);
  modport ram (input wr_en, input rd_en, input addr, input wdata,
    output rdata);
endinterface : wtr_ram_if
`default_nettype wire

// [rtl/wtr_ram.sv]
// template sample memory, one word per sample index
`timescale 1ns/1ps
`default_nettype none
`include "wtr_consts.svh"
module wtr_ram (
  input wire logic aclk,
  wtr_ram_if.ram port
);
  wtr_pkg::wtr_word_t mem [`WTR_SAMPLES];
  wtr_pkg::wtr_word_t rdata_q;

  // no reset on the array: contents are undefined until written
  always_ff @(posedge aclk) begin
    if (port.wr_en && port.addr <= `WTR_LAST_INDEX) begin
      mem[port.addr] <= port.wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (port.rd_en) begin
      if (port.addr <= `WTR_LAST_INDEX) begin
        rdata_q <= mem[port.addr];
      end else begin
        rdata_q <= 7'h00;
      end
    end
  end

  assign port.rdata = rdata_q;
endmodule : wtr_ram
`default_nettype wire

// [verification/wtr_top_tb.sv]
// self-checking bench for the template ram register bank
`timescale 1ns/1ps
`default_nettype none
`include "wtr_consts.svh"
module wtr_top_tb;
  logic aclk;
  logic aresetn;
  logic [11:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [11:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  logic arb_waveform_sel;
  logic [2:0] preset_template;
  int bad_count;
  int num_checks;
  logic [31:0] rd_q;
  logic [1:0] resp_q;
  wtr_top i_wtr_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .arb_waveform_sel(arb_waveform_sel),
    .preset_template(preset_template));
  always #2 aclk = ~aclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // sampled at the rising edge, before that edge's updates land
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    logic aw, w, b;
    b = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!b) begin
      @(posedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      resp_q = s_axi_bresp;
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
      if (b) s_axi_bready <= 1'h0;
    end
    // idle edge: a next call must not re-raise bready in this step
    @(posedge aclk);
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a);
    logic ar, r;
    r = 1'h0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!r) begin
      @(posedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      rd_q = s_axi_rdata;
      resp_q = s_axi_rresp;
      if (ar) s_axi_arvalid <= 1'h0;
      if (r) s_axi_rready <= 1'h0;
    end
    @(posedge aclk);
  endtask : axi_rd
  task automatic t_reset;
    axi_rd(`WTR_ADDR_PULSE_SEL);
    check(rd_q, 32'h2);
    check({30'h0, resp_q}, 32'h0);
    check({31'h0, arb_waveform_sel}, 32'h0);
    axi_rd(`WTR_ADDR_ACCESS_CTRL);
    check(rd_q, 32'h0);
    axi_rd(`WTR_ADDR_SAMPLE_DATA);
    check(rd_q, 32'h0);
    check({29'h0, preset_template}, 32'h2);
    $display("test reset values done");
  endtask : t_reset
  // every selector code, presets and the arbitrary group alike
  task automatic t_presets;
    for (int c = 0; c < 16; c++) begin
      axi_wr(`WTR_ADDR_PULSE_SEL, 32'(c));
      check({31'h0, arb_waveform_sel}, 32'(c >> 3));
      check({29'h0, preset_template}, 32'(c & 7));
      axi_rd(`WTR_ADDR_PULSE_SEL);
      check(rd_q, 32'(c));
    end
    $display("test selector codes done");
  endtask : t_presets
  task automatic t_data;
    axi_wr(`WTR_ADDR_SAMPLE_DATA, 32'hFF);
    check({30'h0, resp_q}, 32'h0);
    axi_rd(`WTR_ADDR_SAMPLE_DATA);
    check(rd_q, 32'h7F);
    axi_wr(`WTR_ADDR_SAMPLE_DATA, 32'h2A);
    axi_rd(`WTR_ADDR_SAMPLE_DATA);
    check(rd_q, 32'h2A);
    $display("test sample data done");
  endtask : t_data
  // preset mode: control write must not start a ram access
  task automatic t_ignore;
    axi_wr(`WTR_ADDR_PULSE_SEL, 32'h2);
    axi_wr(`WTR_ADDR_ACCESS_CTRL, 32'h05);
    repeat (3) @(posedge aclk);
    axi_rd(`WTR_ADDR_ACCESS_CTRL);
    check(rd_q, 32'h05);
    $display("test preset mode ignore done");
  endtask : t_ignore
  task automatic t_arb;
    axi_wr(`WTR_ADDR_PULSE_SEL, 32'h8);
    axi_wr(`WTR_ADDR_ACCESS_CTRL, 32'h12);
    repeat (3) @(posedge aclk);
    axi_rd(`WTR_ADDR_ACCESS_CTRL);
    check(rd_q, 32'h52);
    // read back the sample just stored at the last index
    axi_wr(`WTR_ADDR_ACCESS_CTRL, 32'h32);
    repeat (3) @(posedge aclk);
    axi_rd(`WTR_ADDR_ACCESS_CTRL);
    check(rd_q, 32'h72);
    check({25'h0000000, i_wtr_top.readback_q}, 32'h2A);
    axi_rd(`WTR_ADDR_SAMPLE_DATA);
    check(rd_q, 32'h2A);
    $display("test arbitrary access done");
  endtask : t_arb
  task automatic t_unmapped;
    axi_wr(12'h100, 32'hFF);
    check({30'h0, resp_q}, 32'h2);
    axi_rd(12'h100);
    check(rd_q, 32'h0);
    check({30'h0, resp_q}, 32'h2);
    axi_rd(`WTR_ADDR_SAMPLE_DATA);
    check(rd_q, 32'h2A);
    $display("test unmapped address done");
  endtask : t_unmapped
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  // whole run needs a few hundred cycles; generous margin
  initial begin
    repeat (4000) @(posedge aclk);
    bad_count++;
    end_sim();
  end
  initial begin
    aclk = 1'h0;
    aresetn = 1'h0;
    s_axi_awaddr = 12'h0;
    s_axi_awvalid = 1'h0;
    s_axi_wdata = 32'h0;
    s_axi_wvalid = 1'h0;
    s_axi_bready = 1'h0;
    s_axi_araddr = 12'h0;
    s_axi_arvalid = 1'h0;
    s_axi_rready = 1'h0;
    bad_count = 0;
    num_checks = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset();
    t_presets();
    t_data();
    t_ignore();
    t_arb();
    t_unmapped();
    end_sim();
  end
endmodule : wtr_top_tb
`default_nettype wire
